/* design/lhbp_pkg.sv */
// Package for the host bus port: constants, bit positions, carrier structs.
// Assumes one 10 MHz clock domain; pin inputs synchronous except ready and grant acknowledge.
package lhbp_pkg;
  localparam int          LHBP_CLK_HZ           = 10_000_000;
  localparam int          LHBP_ADDR_W           = 24;
  localparam int          LHBP_DATA_W           = 16;
  localparam int          LHBP_HIGH_W           = 8;
  localparam int          LHBP_STOP_BIT         = 2;
  localparam int          LHBP_INIT_BIT         = 0;
  localparam int          LHBP_STRT_BIT         = 1;
  localparam int          LHBP_INIT_DONE_FLAG_BIT         = 8;
  localparam int          LHBP_TXD_BIT          = 9;
  localparam int          LHBP_RXD_BIT          = 10;
  localparam int          LHBP_MEMORY_ERROR_FLAG_BIT         = 11;
  localparam int          LHBP_MISS_BIT         = 12;
  localparam int          LHBP_BABBLE_ERROR_FLAG_BIT         = 14;
  localparam int          LHBP_ERR_BIT          = 15;
  localparam int          LHBP_ATT_BIT          = 7;
  localparam int          LHBP_AEN_BIT          = 6;
  localparam int          LHBP_PFS_BIT          = 0;
  localparam logic [15:0] LHBP_CSZ_RST          = 16'h0004;
  localparam logic [15:0] LHBP_CS3_RST          = 16'h0000;
  localparam logic [1:0]  LHBP_RAP_RST          = 2'h0;
  localparam logic [15:0] LHBP_FLAG_W1C         = 16'h5f00;
  localparam logic [15:0] LHBP_ATT_SRC          = 16'h5f00;

  typedef struct packed {
    logic                   req;
    logic                   write;
    logic [LHBP_ADDR_W-1:0] addr;
    logic [LHBP_DATA_W-1:0] wdata;
  } lhbp_dma_req_s;

  typedef struct packed {
    logic       init_done;
    logic       tx_done;
    logic       rx_done;
    logic       mem_err;
    logic       missed;
    logic       babble;
  } lhbp_event_s;
endpackage

/* design/lhbp_port.sv */
// Host bus port: master DMA cycles, bus request/grant, slave register access.
// Assumes a testbench resolves open-drain and three-state pins from enables.
// Functional notes
// - Address phase drives low 16 bits on mux lines, upper 8 on high lines.
// - Data phase carries read or write data, as master and as slave.
// - Inbound transceiver control low in read data phase, high for writes.
// - Outbound control low only in read address phase, low through a write.
// - Data strobe high in address phase, low in data phase as master.
// - Mastership begins only when grant acknowledge goes low after request.
// - No new request until grant acknowledge has returned high.
// - Request pulled low when memory access needed, held for the whole transaction.
// - Control three bit 0 selects request pin role; reset clears it.
// - Sample shared request line; request only when it is high.
// - Attention active while any source flag set and enable bit 6 set.
// - Status zero bit 7 shows any interrupt condition regardless of enable.
// - As master, direction high for memory read, low for memory write.
// - As slave, direction high means device drives data, low means device takes.
// - Master accepts asynchronous ready from memory as data accepted or valid.
// - Slave asserts ready on the same edge as the read data or the write; releases after strobe high.
// - Reset stops everything, floats three-state outputs, sets stop bit.
// - Master addresses are 24-bit linear across mux and high lines.
// - Interrupt causes: init, receive, transmit, babble, missed, memory error.
// - Port select low picks data port, high picks pointer, used only with chip select.
module lhbp_port
  import lhbp_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire lhbp_dma_req_s          dma_req_in,
  input  wire lhbp_event_s            event_in,
  output logic                        dma_done_out,
  output logic [LHBP_DATA_W-1:0]      dma_rdata_out,
  input  wire logic [LHBP_DATA_W-1:0] mad_in,
  output logic [LHBP_DATA_W-1:0]      mad_out,
  output logic                        mad_oe_out,
  output logic [LHBP_HIGH_W-1:0]      high_address_lines_out,
  output logic                        high_oe_out,
  output logic                        inbound_xcvr_ctl_out,
  output logic                        outbound_xcvr_ctl_out,
  output logic                        xcvr_oe_out,
  input  wire logic                   data_phase_strobe_in,
  output logic                        data_phase_strobe_out,
  output logic                        strobe_oe_out,
  input  wire logic                   direction_in,
  output logic                        direction_out,
  output logic                        direction_oe_out,
  input  wire logic                   ready_in,
  output logic                        ready_oe_out,
  input  wire logic                   grant_ack_in,
  input  wire logic                   chain_bus_request_in,
  output logic                        chain_bus_request_oe_out,
  input  wire logic                   chip_select_n_in,
  input  wire logic                   port_select_in,
  output logic                        attention_oe_out,
  output logic                        stop_out,
  output logic                        pin_function_select_out
);
  typedef enum logic [2:0] {M_IDLE, M_WAIT, M_ADDR, M_DATA, M_END, M_RELEASE} lhbp_mst_e;
  lhbp_mst_e        mst_r;
  logic [1:0]       rdy_sync_r;
  logic [1:0]       gnt_sync_r;
  logic [15:0]      csz_r;
  logic [15:0]      cs1_r;
  logic [15:0]      cs2_r;
  logic [15:0]      cs3_r;
  logic [1:0]       rap_r;
  logic             slv_busy_r;
  logic             rdy_n;
  logic             gnt_n;
  logic             att_any;
  logic [15:0]      reg_rdata;
  logic [15:0]      csz_view;
  logic [15:0]      ev_vec;
  logic             wr_strobe;

  // Synchronisers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_sync_r <= 2'h3;
      gnt_sync_r <= 2'h3;
    end else begin
      rdy_sync_r <= {rdy_sync_r[0], ready_in};
      gnt_sync_r <= {gnt_sync_r[0], grant_ack_in};
    end
  end
  assign rdy_n = rdy_sync_r[1];
  assign gnt_n = gnt_sync_r[1];

  // Event vector
  always_comb begin
    ev_vec                = 16'h0000;
    ev_vec[LHBP_INIT_DONE_FLAG_BIT] = event_in.init_done;
    ev_vec[LHBP_TXD_BIT]  = event_in.tx_done;
    ev_vec[LHBP_RXD_BIT]  = event_in.rx_done;
    ev_vec[LHBP_MEMORY_ERROR_FLAG_BIT] = event_in.mem_err;
    ev_vec[LHBP_MISS_BIT] = event_in.missed;
    ev_vec[LHBP_BABBLE_ERROR_FLAG_BIT] = event_in.babble;
  end
  assign att_any = |(csz_r & LHBP_ATT_SRC);

  always_comb begin
    csz_view               = csz_r;
    csz_view[LHBP_ATT_BIT] = att_any;
    csz_view[LHBP_ERR_BIT] = |(csz_r & 16'h5800);
  end

  // Slave read mux
  always_comb begin
    reg_rdata = 16'h0000;
    if (port_select_in) begin
      reg_rdata = {14'h0000, rap_r};
    end else begin
      case (rap_r)
        2'h0:    reg_rdata = csz_view;
        2'h1:    reg_rdata = cs1_r;
        2'h2:    reg_rdata = cs2_r;
        2'h3:    reg_rdata = cs3_r;
        default: reg_rdata = 16'h0000;
      endcase
    end
  end

  // Slave cycle: chip select low, strobe low, never while bus is granted
  assign wr_strobe = !chip_select_n_in && !data_phase_strobe_in && !direction_in
                     && !slv_busy_r && (mst_r == M_IDLE);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      slv_busy_r   <= 1'b0;
      ready_oe_out <= 1'b0;
    end else if (!chip_select_n_in && !data_phase_strobe_in && mst_r == M_IDLE) begin
      slv_busy_r   <= 1'b1;
      ready_oe_out <= 1'b1;
    end else if (data_phase_strobe_in || chip_select_n_in) begin
      slv_busy_r   <= 1'b0;
      ready_oe_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mad_out    <= 16'h0000;
      mad_oe_out <= 1'b0;
    end else if (mst_r == M_WAIT && !gnt_n) begin
      mad_out    <= dma_req_in.addr[15:0];
      mad_oe_out <= 1'b1;
    end else if (mst_r == M_ADDR || mst_r == M_DATA) begin
      mad_out    <= dma_req_in.wdata;
      mad_oe_out <= dma_req_in.write;
    end else if (!chip_select_n_in && direction_in && mst_r == M_IDLE) begin
      mad_out    <= reg_rdata;
      mad_oe_out <= 1'b1;
    end else begin
      mad_oe_out <= 1'b0;
    end
  end

  // Register writes; hardware set wins over software clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      csz_r <= LHBP_CSZ_RST;
      cs1_r <= 16'h0000;
      cs2_r <= 16'h0000;
      cs3_r <= LHBP_CS3_RST;
      rap_r <= LHBP_RAP_RST;
    end else begin
      if (wr_strobe && port_select_in) begin
        rap_r <= mad_in[1:0];
      end
      if (wr_strobe && !port_select_in) begin
        case (rap_r)
          2'h0: begin
            csz_r <= (csz_r & ~(mad_in & LHBP_FLAG_W1C)) | ev_vec;
            csz_r[LHBP_AEN_BIT] <= mad_in[LHBP_AEN_BIT];
            if (mad_in[LHBP_STOP_BIT]) begin
              csz_r[LHBP_STOP_BIT] <= 1'b1;
            end else if (mad_in[LHBP_INIT_BIT] || mad_in[LHBP_STRT_BIT]) begin
              csz_r[LHBP_STOP_BIT] <= 1'b0;
            end
          end
          2'h1: if (csz_r[LHBP_STOP_BIT]) cs1_r <= mad_in;
          2'h2: if (csz_r[LHBP_STOP_BIT]) cs2_r <= {8'h00, mad_in[7:0]};
          2'h3: if (csz_r[LHBP_STOP_BIT]) cs3_r <= {13'h0000, mad_in[2:0]};
          default: ;
        endcase
        if (rap_r != 2'h0) begin
          csz_r <= csz_r | ev_vec;
        end
      end else begin
        csz_r <= csz_r | ev_vec;
      end
    end
  end

  // Master sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mst_r <= M_IDLE;
    end else begin
      case (mst_r)
        M_IDLE: if (dma_req_in.req && !csz_r[LHBP_STOP_BIT] && gnt_n
                    && chip_select_n_in && chain_bus_request_in) mst_r <= M_WAIT;
        M_WAIT: if (!gnt_n) mst_r <= M_ADDR;
        M_ADDR: mst_r <= M_DATA;
        M_DATA: if (!rdy_n) mst_r <= M_END;
        M_END:  mst_r <= M_RELEASE;
        M_RELEASE: if (gnt_n) mst_r <= M_IDLE;
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  // Master pin drive
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chain_bus_request_oe_out <= 1'b0;
      high_address_lines_out   <= 8'h00;
      high_oe_out              <= 1'b0;
      inbound_xcvr_ctl_out     <= 1'b1;
      outbound_xcvr_ctl_out    <= 1'b1;
      xcvr_oe_out              <= 1'b0;
      data_phase_strobe_out    <= 1'b1;
      strobe_oe_out            <= 1'b0;
      direction_out            <= 1'b0;
      direction_oe_out         <= 1'b0;
      dma_done_out             <= 1'b0;
      dma_rdata_out            <= 16'h0000;
    end else begin
      chain_bus_request_oe_out <= (mst_r == M_IDLE && dma_req_in.req && !csz_r[LHBP_STOP_BIT]
                                   && gnt_n && chip_select_n_in && chain_bus_request_in)
                                  || mst_r == M_WAIT || mst_r == M_ADDR
                                  || mst_r == M_DATA;
      high_oe_out           <= (mst_r == M_WAIT && !gnt_n) || mst_r == M_ADDR
                               || mst_r == M_DATA;
      high_address_lines_out <= dma_req_in.addr[23:16];
      xcvr_oe_out           <= (mst_r == M_WAIT && !gnt_n) || mst_r == M_ADDR
                               || mst_r == M_DATA;
      inbound_xcvr_ctl_out  <= !(!dma_req_in.write && (mst_r == M_ADDR
                               || (mst_r == M_DATA && rdy_n)));
      outbound_xcvr_ctl_out <= !(dma_req_in.write || (mst_r == M_WAIT && !gnt_n));
      strobe_oe_out         <= (mst_r == M_WAIT && !gnt_n) || mst_r == M_ADDR
                               || mst_r == M_DATA;
      data_phase_strobe_out <= !(mst_r == M_ADDR || (mst_r == M_DATA && rdy_n));
      direction_oe_out      <= (mst_r == M_WAIT && !gnt_n) || mst_r == M_ADDR
                               || mst_r == M_DATA;
      direction_out         <= !dma_req_in.write;
      dma_done_out          <= (mst_r == M_DATA && !rdy_n);
      if (mst_r == M_DATA && !rdy_n && !dma_req_in.write) begin
        dma_rdata_out <= mad_in;
      end
    end
  end

  // Attention, stop and mode outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      attention_oe_out        <= 1'b0;
      stop_out                <= 1'b1;
      pin_function_select_out <= 1'b0;
    end else begin
      attention_oe_out        <= att_any && csz_r[LHBP_AEN_BIT];
      stop_out                <= csz_r[LHBP_STOP_BIT];
      pin_function_select_out <= cs3_r[LHBP_PFS_BIT];
    end
  end

  // Address phase: strobe high, address driven
  sequence s_addr_phase;
    data_phase_strobe_out && strobe_oe_out && mad_oe_out;
  endsequence

  a_release_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_RELEASE && !gnt_n) |=> mst_r == M_RELEASE)
    else $error("request re-armed before grant release");
  a_grant_start: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_ADDR) |-> $past(!gnt_n))
    else $error("mastership without grant");
  a_attn_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 attention_oe_out == $past(att_any && csz_r[LHBP_AEN_BIT]))
    else $error("attention mismatch");
  a_poll_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    csz_view[LHBP_ATT_BIT] == (csz_r[LHBP_BABBLE_ERROR_FLAG_BIT] || csz_r[LHBP_MEMORY_ERROR_FLAG_BIT]
      || csz_r[LHBP_MISS_BIT] || csz_r[LHBP_RXD_BIT] || csz_r[LHBP_TXD_BIT]
      || csz_r[LHBP_INIT_DONE_FLAG_BIT]))
    else $error("poll bit wrong");
  a_req_held: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_DATA) |=> chain_bus_request_oe_out)
    else $error("request dropped in transaction");
  a_addr_phase: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_ADDR) |-> s_addr_phase)
    else $error("address phase without strobe high");
  a_strobe_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_ADDR) |=> data_phase_strobe_out == 1'b0 && strobe_oe_out)
    else $error("strobe not low in data phase");
  a_dir_master: assert property (@(posedge clk_in) disable iff (rst_in)
    (mst_r == M_DATA) |=> direction_out == !$past(dma_req_in.write))
    else $error("direction wrong");
  a_ready_release: assert property (@(posedge clk_in) disable iff (rst_in)
    (ready_oe_out && data_phase_strobe_in) |=> !ready_oe_out)
    else $error("ready held after strobe high");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    event_in.babble |=> csz_r[LHBP_BABBLE_ERROR_FLAG_BIT])
    else $error("event flag lost");
endmodule

/* tb/lhbp_mem_model.sv */
// Arbiter and shared memory on the far side of the host bus port.
// Assumes the bench resolves pins; grant and ready are active low.
module lhbp_mem_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        request_n_in,
  input  wire logic        strobe_n_in,
  input  wire logic        strobe_oe_in,
  input  wire logic        read_in,
  input  wire logic        addr_oe_in,
  input  wire logic [23:0] bus_in,
  input  wire logic [3:0]  wait_in,
  output logic             grant_n_out,
  output logic             ready_n_out,
  output logic             data_oe_out,
  output logic [15:0]      data_out,
  output logic [23:0]      last_addr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem_r [16];
  logic [3:0]  wait_r;
  logic        data_ph_r;
  // Data phase seen since strobe drive began; address only before it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) data_ph_r <= 1'b0;
    else data_ph_r <= strobe_oe_in && (data_ph_r || !strobe_n_in);
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) grant_n_out <= 1'b1;
    else grant_n_out <= request_n_in;
  end
  always_ff @(posedge clk_in) begin
    if (addr_oe_in && strobe_oe_in && strobe_n_in && !data_ph_r) last_addr_out <= bus_in;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_r <= 4'h0;
      ready_n_out <= 1'b1;
    end else if (strobe_oe_in && !strobe_n_in) begin
      if (wait_r == wait_in) ready_n_out <= 1'b0;
      else wait_r <= wait_r + 4'h1;
    end else begin
      wait_r <= 4'h0;
      ready_n_out <= 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!ready_n_out && !read_in && !strobe_n_in) mem_r[last_addr_out[3:0]] <= bus_in[15:0];
  end
  assign data_oe_out = strobe_oe_in && !strobe_n_in && read_in;
  assign data_out = mem_r[last_addr_out[3:0]];
endmodule

/* tb/lhbp_port_tb.sv */
// Self-checking bench for the host bus port with a memory model.
// Assumes open-drain and three-state pins are resolved here.
module lhbp_port_tb import lhbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic          clk_in = 1'b0;
  logic          rst_in = 1'b1;
  lhbp_dma_req_s dma_req = '0;
  lhbp_event_s   event_r = '0;
  logic          cs_n = 1'b1;
  logic          port_sel = 1'b0;
  logic          host_dir = 1'b0;
  logic          host_strobe = 1'b1;
  logic          other_req = 1'b0;
  logic [15:0]   host_data = 16'h0000;
  logic [3:0]    wait_cyc = 4'h0;
  logic          dma_done, mad_oe, strobe_out, strobe_oe, dir_out, dir_oe, ready_oe;
  logic          req_oe, attn, stop, pfs, grant_n, mem_ready_n, mem_oe;
  logic          inb, outb, xoe, hoe;
  logic [15:0]   rdata, mad_out, mem_data;
  logic [7:0]    high;
  logic [23:0]   last_addr;
  int            failures = 0;
  int            samples_checked = 0;
  wire logic [15:0] mad = mad_oe ? mad_out : mem_oe ? mem_data : host_data;
  wire logic        strobe = strobe_oe ? strobe_out : host_strobe;
  wire logic        dir = dir_oe ? dir_out : host_dir;
  wire logic        ready_n = !(ready_oe || !mem_ready_n);
  wire logic        req_n = !(req_oe || other_req);
  always #50 clk_in = ~clk_in;
  lhbp_port u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .dma_req_in(dma_req), .event_in(event_r),
    .dma_done_out(dma_done), .dma_rdata_out(rdata), .mad_in(mad), .mad_out(mad_out),
    .mad_oe_out(mad_oe), .high_address_lines_out(high), .high_oe_out(hoe),
    .inbound_xcvr_ctl_out(inb), .outbound_xcvr_ctl_out(outb), .xcvr_oe_out(xoe),
    .data_phase_strobe_in(strobe), .data_phase_strobe_out(strobe_out),
    .strobe_oe_out(strobe_oe), .direction_in(dir), .direction_out(dir_out),
    .direction_oe_out(dir_oe), .ready_in(ready_n), .ready_oe_out(ready_oe),
    .grant_ack_in(grant_n), .chain_bus_request_in(req_n),
    .chain_bus_request_oe_out(req_oe), .chip_select_n_in(cs_n),
    .port_select_in(port_sel), .attention_oe_out(attn), .stop_out(stop),
    .pin_function_select_out(pfs));
  lhbp_mem_model u_mem (
    .clk_in(clk_in), .rst_in(rst_in), .request_n_in(req_n), .strobe_n_in(strobe),
    .strobe_oe_in(strobe_oe), .read_in(dir_out), .addr_oe_in(mad_oe),
    .bus_in({high, mad_out}), .wait_in(wait_cyc), .grant_n_out(grant_n),
    .ready_n_out(mem_ready_n), .data_oe_out(mem_oe), .data_out(mem_data),
    .last_addr_out(last_addr));
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check1(input string what, input logic seen, input logic exp);
    check(what, {23'h00_0000, seen}, {23'h00_0000, exp});
  endtask
  task automatic timed_out(input string what);
    check1(what, 1'b0, 1'b1);
    end_of_test();
  endtask
  task automatic host_xfer(input logic ps, input logic wr, input logic [15:0] wd,
                           output logic [15:0] rd);
    int n;
    @(posedge clk_in);
    cs_n <= 1'b0;
    port_sel <= ps;
    host_dir <= !wr;
    host_data <= wd;
    host_strobe <= 1'b0;
    for (n = 0; n < 20 && ready_oe !== 1'b1; n++) @(posedge clk_in);
    if (n == 20) timed_out("slave ready");
    rd = mad;
    cs_n <= 1'b1;
    host_strobe <= 1'b1;
    for (n = 0; n < 20 && ready_oe !== 1'b0; n++) @(posedge clk_in);
    if (n == 20) timed_out("slave ready release");
  endtask
  task automatic reg_access(input logic [1:0] idx, input logic wr, input logic [15:0] wd,
                            output logic [15:0] rd);
    host_xfer(1'b1, 1'b1, {14'h0000, idx}, rd);
    host_xfer(1'b0, wr, wd, rd);
  endtask
  task automatic slave_setup();
    logic [15:0] rd;
    reg_access(2'h3, 1'b1, 16'h0001, rd);
    check1("pin role", pfs, 1'b1);
    host_xfer(1'b1, 1'b0, 16'h0000, rd);
    check("pointer", {22'h00_0000, rd[1:0]}, 24'h00_0003);
    reg_access(2'h1, 1'b1, 16'h1234, rd);
    reg_access(2'h2, 1'b1, 16'h00c3, rd);
    reg_access(2'h1, 1'b0, 16'h0000, rd);
    check("init address low", {8'h00, rd}, 24'h00_1234);
    reg_access(2'h2, 1'b0, 16'h0000, rd);
    check("init address high", {8'h00, rd}, 24'h00_00c3);
    reg_access(2'h0, 1'b1, 16'h0002, rd);
    check1("stop cleared", stop, 1'b0);
    reg_access(2'h1, 1'b1, 16'hffff, rd);
    reg_access(2'h1, 1'b0, 16'h0000, rd);
    check("locked while running", {8'h00, rd}, 24'h00_1234);
  endtask
  task automatic dma(input logic wr, input logic [23:0] a, input logic [15:0] d,
                     input int hold, input logic [3:0] wt);
    int n;
    @(posedge clk_in);
    wait_cyc <= wt;
    other_req <= (hold != 0);
    dma_req <= '{req: 1'b1, write: wr, addr: a, wdata: d};
    repeat (hold) @(posedge clk_in);
    if (hold != 0) check1("request on busy line", req_oe, 1'b0);
    other_req <= 1'b0;
    for (n = 0; n < 60 && dma_done !== 1'b1; n++) begin
      if (strobe_oe === 1'b1 && strobe_out === 1'b0) begin
        check("data phase pins", {18'h0_0000, inb, outb, xoe, hoe, dir_out, dir_oe},
              {18'h0_0000, wr, !wr, 1'b1, 1'b1, !wr, 1'b1});
      end
      @(posedge clk_in);
    end
    if (n == 60) timed_out("dma done");
    check1("request held", req_oe, 1'b1);
    check("high lines", {16'h0000, high}, {16'h0000, a[23:16]});
    if (!wr) check("dma read data", {8'h00, rdata}, {8'h00, d});
    check("dma address", last_addr, a);
    dma_req.req <= 1'b0;
    for (n = 0; n < 20 && grant_n !== 1'b1; n++) @(posedge clk_in);
    if (n == 20) timed_out("grant release");
  endtask
  task automatic attention();
    logic [15:0] rd;
    @(posedge clk_in);
    event_r.rx_done <= 1'b1;
    event_r.babble <= 1'b1;
    @(posedge clk_in);
    event_r.rx_done <= 1'b0;
    event_r.babble <= 1'b0;
    reg_access(2'h0, 1'b0, 16'h0000, rd);
    check1("poll bit", rd[LHBP_ATT_BIT], 1'b1);
    check1("receive flag", rd[LHBP_RXD_BIT], 1'b1);
    check1("babble flag", rd[LHBP_BABBLE_ERROR_FLAG_BIT], 1'b1);
    check1("attention masked", attn, 1'b0);
    reg_access(2'h0, 1'b1, 16'h0040, rd);
    repeat (2) @(posedge clk_in);
    check1("attention on", attn, 1'b1);
    reg_access(2'h0, 1'b1, 16'h5f40, rd);
    repeat (2) @(posedge clk_in);
    check1("attention off", attn, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    check1("stop at reset", stop, 1'b1);
    check("drives at reset", {16'h0000, mad_oe, strobe_oe, req_oe, attn, ready_oe, dir_oe,
          xoe, hoe}, 24'h00_0000);
    check1("pin role at reset", pfs, 1'b0);
    rst_in <= 1'b0;
    slave_setup();
    dma(1'b1, 24'hc3_0005, 16'hbeef, 6, 4'h0);
    dma(1'b0, 24'hc3_0005, 16'hbeef, 0, 4'h3);
    dma(1'b1, 24'h3c_000a, 16'h0ff0, 0, 4'h1);
    dma(1'b0, 24'h3c_000a, 16'h0ff0, 0, 4'h0);
    attention();
    end_of_test();
  end
endmodule
